// file: testbench/burst_read_query_table_host.sv
// host memory controller model issuing apb query transfers
`timescale 1ns/1ns
`default_nettype none
module burst_read_query_table_host (
  // clock
  input wire logic clock_i,
  // apb master side
  output var burst_read_query_table_pkg::apb_req_s apb_req_o,
  input wire burst_read_query_table_pkg::apb_rsp_s apb_rsp_i
);
  // bus idle from time zero
  initial begin
    apb_req_o = '0;
  end
  // host copies an entry's code straight into its burst length bits
  function automatic logic [2:0] burst_bits(input logic [7:0] entry);
    return entry[2:0];
  endfunction
  // one transfer: setup, then access held until pready is seen high or 64 cycles pass
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e,
                      output logic tmo);
    int n;
    apb_req_o <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge clock_i);
    apb_req_o.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (apb_rsp_i.pready !== 1'b1 && n < 64);
    r = apb_rsp_i.prdata;
    e = apb_rsp_i.pslverr;
    tmo = (apb_rsp_i.pready !== 1'b1);
    // released lines show the inverse so stale values cannot pass
    apb_req_o <= '{1'b0, 1'b0, ~w, ~a, ~d, ~s};
  endtask
endmodule // burst_read_query_table_host
`default_nettype wire

// file: testbench/burst_read_query_table_tb_top.sv
// testbench for the burst read query table
`timescale 1ns/1ns
`default_nettype none
module burst_read_query_table_tb_top;
  logic clock_i;
  logic rst_i;
  burst_read_query_table_pkg::apb_req_s apb_req;
  burst_read_query_table_pkg::apb_rsp_s apb_rsp;
  logic query_en;
  int err_count;
  int compares;
  logic [31:0] rdata;
  logic rerr;
  logic tmo;
  logic [7:0] exp_tab [7] = '{8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, 8'h02};
  logic [11:0] bad [3] = '{12'h4a4, 12'h4a5, 12'h4b8};
  // device with a nonzero partition region count
  burst_read_query_table #(.PAGE_EXP(8'h03), .PART_REGIONS(8'h02)) dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .apb_req_i(apb_req),
    .apb_rsp_o(apb_rsp),
    .query_en_o(query_en)
  );
  burst_read_query_table_host host (
    .clock_i(clock_i),
    .apb_req_o(apb_req),
    .apb_rsp_i(apb_rsp)
  );
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one bus transfer, then one idle cycle
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    host.xfer(w, a, d, s, rdata, rerr, tmo);
    if (tmo) begin
      err_count++;
      $display("unexpected at %0t: no pready", $time);
      close_out();
    end
    @(posedge clock_i);
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    $display("unexpected at %0t: run too long", $time);
    close_out();
  end
  // main sequence
  initial begin
    rst_i <= 1'b1;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check({31'h0, query_en}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, 12'h49c + 12'(4 * i), 32'h0, 4'h0);
      check(rdata, {24'h0, exp_tab[i]});
      check({31'h0, rerr}, 32'h0);
    end
    acc(1'b0, 12'h4b0, 32'h0, 4'h0);
    check({29'h0, host.burst_bits(rdata[7:0])}, 32'h7);
    $display("test table done");
    // write to table, misaligned read, unmapped read
    for (int i = 0; i < 3; i++) begin
      acc(i == 0, bad[i], 32'hffff_ffff, 4'hf);
      check({31'h0, rerr}, 32'h1);
      check(rdata, 32'h0);
    end
    acc(1'b0, 12'h4a4, 32'h0, 4'h0);
    check(rdata, 32'h1);
    $display("test refusals done");
    // control write without strobe is ignored, with strobe hides table
    acc(1'b1, 12'h4c0, 32'h0, 4'h0);
    check({31'h0, query_en}, 32'h1);
    acc(1'b1, 12'h4c0, 32'h0, 4'h1);
    check({31'h0, query_en}, 32'h0);
    acc(1'b0, 12'h49c, 32'h0, 4'h0);
    check(rdata, 32'h0);
    $display("test query off done");
    // reset in mid-run restores query space
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check({31'h0, query_en}, 32'h1);
    acc(1'b0, 12'h49c, 32'h0, 4'h0);
    check(rdata, 32'h3);
    $display("test second reset done");
    close_out();
  end
endmodule // burst_read_query_table_tb_top
`default_nettype wire

// file: verilog/burst_read_query_table.sv
// apb slave presenting the burst read and partition query locations
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "burst_read_query_table_defines.svh"
module burst_read_query_table #(
  parameter logic [7:0] PAGE_EXP = `PAGE_SIZE_CODE,
  parameter logic [7:0] PART_REGIONS = `PART_COUNT_CODE
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // apb slave port
  input wire burst_read_query_table_pkg::apb_req_s apb_req_i,
  output var burst_read_query_table_pkg::apb_rsp_s apb_rsp_o,
  // query space visible to the flash read path
  output logic query_en_o
);

  localparam int ENTRIES = 4;

  // burst entry codes, index 0 is the first entry
  localparam logic [7:0] ENTRY_CODE [ENTRIES] = '{
    `ENTRY_ONE_CODE, `ENTRY_TWO_CODE, `ENTRY_THREE_CODE, `ENTRY_FOUR_CODE
  };

  // elaboration check: a page exponent beyond 31 cannot describe a buffer
  if (PAGE_EXP > 8'h1f) begin : g_bad_page
    $error("page size exponent out of range");
  end

  // elaboration check: the entry table must match the advertised count
  if (8'(ENTRIES) != `ENTRY_COUNT_CODE) begin : g_bad_count
    $error("entry table does not match the entry count");
  end

  burst_read_query_table_pkg::state_s state_reg;
  burst_read_query_table_pkg::state_s state_next;

  logic setup;
  logic access;
  logic aligned;
  logic [9:0] index;
  logic [ENTRIES-1:0] entry_hit;
  logic [7:0] entry_byte [ENTRIES];
  logic [7:0] entry_data;
  logic table_hit;
  logic [7:0] table_byte;

  // phase decode of the apb transfer
  assign setup = apb_req_i.psel && !apb_req_i.penable;
  assign access = apb_req_i.psel && apb_req_i.penable;
  assign aligned = apb_req_i.paddr[1:0] == 2'b00;
  assign index = apb_req_i.paddr[11:2];

  // one decoder per synchronous configuration entry
  for (genvar k = 0; k < ENTRIES; k++) begin : g_entry
    assign entry_hit[k] = index == (`ENTRY_ONE_IDX + 10'(k));
    // reserved bits 3-7 forced to zero
    assign entry_byte[k] = entry_hit[k] ?
      (ENTRY_CODE[k] & `BURST_CODE_MASK) : 8'h00;
  end

  // entries never overlap, so an or merges them
  assign entry_data = entry_byte[0] | entry_byte[1] |
                      entry_byte[2] | entry_byte[3];

  // table lookup of the query byte for the addressed location
  always_comb begin
    table_hit = 1'b1;
    table_byte = 8'h00;
    case (index)
      `PAGE_SIZE_IDX: table_byte = PAGE_EXP;
      `ENTRY_COUNT_IDX: table_byte = 8'(ENTRIES);
      `ENTRY_ONE_IDX,
      `ENTRY_TWO_IDX,
      `ENTRY_THREE_IDX,
      `ENTRY_FOUR_IDX: table_byte = entry_data;
      `PART_COUNT_IDX: table_byte = PART_REGIONS;
      default: table_hit = 1'b0;
    endcase
  end

  // next state: read data and error captured in setup, writes in access
  always_comb begin
    state_next = state_reg;
    if (setup) begin
      state_next.prdata = 32'h0000_0000;
      state_next.pslverr = 1'b0;
      if (!aligned) begin
        state_next.pslverr = 1'b1;
      end else if (index == `QUERY_CTRL_IDX) begin
        state_next.prdata[`QUERY_EN_BIT] = state_reg.query_en;
      end else if (table_hit && !apb_req_i.pwrite) begin
        // hidden outside query mode, upper bytes always zero
        if (state_reg.query_en) begin
          state_next.prdata = {24'h00_0000, table_byte};
        end
      end else begin
        // unmapped address or write to a read-only location
        state_next.pslverr = 1'b1;
      end
    end
    if (access && apb_req_i.pwrite && !state_reg.pslverr &&
        index == `QUERY_CTRL_IDX && apb_req_i.pstrb[0]) begin
      state_next.query_en = apb_req_i.pwdata[`QUERY_EN_BIT];
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= '{prdata: `PRDATA_RESET, pslverr: `PSLVERR_RESET,
                     query_en: `QUERY_EN_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // zero wait state answer
  assign apb_rsp_o = '{prdata: state_reg.prdata,
                       pready: 1'b1,
                       pslverr: state_reg.pslverr};
  assign query_en_o = state_reg.query_en;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  logic q_read;
  assign q_read = setup && !apb_req_i.pwrite && aligned && state_reg.query_en;

  property p_page_code;
    q_read && index == `PAGE_SIZE_IDX |=> apb_rsp_o.prdata == {24'h0, PAGE_EXP};
  endproperty
  a_page_code: assert property (p_page_code)
    else $error("page size code wrong");

  property p_no_page;
    q_read && index == `PAGE_SIZE_IDX |=>
      ((apb_rsp_o.prdata == 32'h0) == (PAGE_EXP == 8'h00));
  endproperty
  a_no_page: assert property (p_no_page)
    else $error("page buffer absence misreported");

  property p_entry_count;
    q_read && index == `ENTRY_COUNT_IDX |=>
      apb_rsp_o.prdata == 32'h0000_0004 && !apb_rsp_o.pslverr;
  endproperty
  a_entry_count: assert property (p_entry_count)
    else $error("entry count wrong");

  property p_entry_reserved;
    q_read && index >= `ENTRY_ONE_IDX && index <= `ENTRY_FOUR_IDX |=>
      apb_rsp_o.prdata[7:3] == 5'h00 && apb_rsp_o.prdata[2:0] != 3'h0;
  endproperty
  a_entry_reserved: assert property (p_entry_reserved)
    else $error("entry reserved bits set");

  property p_continuous;
    q_read && index == `ENTRY_FOUR_IDX |=>
      apb_rsp_o.prdata[2:0] == `BURST_CONTINUOUS;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous entry missing");

  property p_entries;
    q_read && index == `ENTRY_ONE_IDX ##[2:3]
      q_read && index == `ENTRY_TWO_IDX
      |=> $past(apb_rsp_o.prdata) == 32'h1 && apb_rsp_o.prdata == 32'h2;
  endproperty
  a_entries: assert property (p_entries)
    else $error("entry sequence wrong");

  property p_entry_three;
    q_read && index == `ENTRY_THREE_IDX |=> apb_rsp_o.prdata == 32'h3;
  endproperty
  a_entry_three: assert property (p_entry_three)
    else $error("third entry wrong");

  property p_partitions;
    q_read && index == `PART_COUNT_IDX |=>
      apb_rsp_o.prdata[7:0] == PART_REGIONS && !apb_rsp_o.pslverr;
  endproperty
  a_partitions: assert property (p_partitions)
    else $error("partition count wrong");

  property p_ctrl_reserved;
    setup && aligned && index == `QUERY_CTRL_IDX |=>
      apb_rsp_o.prdata[31:1] == 31'h0 &&
      apb_rsp_o.prdata[0] == $past(state_reg.query_en);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control register readback wrong");

  property p_upper_zero;
    access && !apb_req_i.pwrite |-> apb_rsp_o.prdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper data bits not zero");

  property p_unmapped;
    setup && (!aligned || (!table_hit && index != `QUERY_CTRL_IDX))
      |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  // protocol and control checks, plus further entry and partition table content checks
  property p_ready;
    access |->
      apb_rsp_o.pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase not answered");

  property p_entry_one;
    q_read && index == `ENTRY_ONE_IDX |=>
      apb_rsp_o.prdata == {24'h00_0000, `ENTRY_ONE_CODE};
  endproperty
  a_entry_one: assert property (p_entry_one)
    else $error("first entry wrong");

  property p_entry_two;
    q_read && index == `ENTRY_TWO_IDX |=>
      apb_rsp_o.prdata == {24'h00_0000, `ENTRY_TWO_CODE};
  endproperty
  a_entry_two: assert property (p_entry_two)
    else $error("second entry wrong");

  property p_entry_four;
    q_read && index == `ENTRY_FOUR_IDX |=>
      apb_rsp_o.prdata == {24'h00_0000, `ENTRY_FOUR_CODE};
  endproperty
  a_entry_four: assert property (p_entry_four)
    else $error("fourth entry wrong");

  property p_part_single;
    q_read && index == `PART_COUNT_IDX |=>
      ((apb_rsp_o.prdata == 32'h0000_0000) == (PART_REGIONS == 8'h00));
  endproperty
  a_part_single: assert property (p_part_single)
    else $error("single partition misreported");

  property p_hidden;
    setup && !apb_req_i.pwrite && aligned && table_hit && !query_en_o |=>
      apb_rsp_o.prdata == 32'h0000_0000 && !apb_rsp_o.pslverr;
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("table visible outside query mode");

  property p_table_write;
    setup && apb_req_i.pwrite && aligned && table_hit |=>
      apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000;
  endproperty
  a_table_write: assert property (p_table_write)
    else $error("write to table not refused");

  property p_known_ok;
    q_read && table_hit |=>
      !apb_rsp_o.pslverr;
  endproperty
  a_known_ok: assert property (p_known_ok)
    else $error("table read refused");

  property p_ctrl_read_ok;
    setup && aligned && index == `QUERY_CTRL_IDX |=>
      !apb_rsp_o.pslverr;
  endproperty
  a_ctrl_read_ok: assert property (p_ctrl_read_ok)
    else $error("control access refused");

  property p_err_zero;
    apb_rsp_o.pslverr |->
      apb_rsp_o.prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused transfer carries data");

  property p_stands;
    !setup |=>
      $stable(apb_rsp_o.prdata) && $stable(apb_rsp_o.pslverr);
  endproperty
  a_stands: assert property (p_stands)
    else $error("answer changed outside setup");

  property p_ctrl_hold;
    !(access && apb_req_i.pwrite && index == `QUERY_CTRL_IDX) |=>
      $stable(query_en_o);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("query enable changed without write");

  property p_ctrl_write;
    access && apb_req_i.pwrite && index == `QUERY_CTRL_IDX &&
      apb_req_i.pstrb[0] && !apb_rsp_o.pslverr |=>
      query_en_o == $past(apb_req_i.pwdata[`QUERY_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("query enable write lost");

  property p_strobe_off;
    access && apb_req_i.pwrite && !apb_req_i.pstrb[0] |=>
      $stable(query_en_o);
  endproperty
  a_strobe_off: assert property (p_strobe_off)
    else $error("unstrobed write changed query enable");

endmodule // burst_read_query_table
`default_nettype wire

// file: verilog/burst_read_query_table_defines.svh
// constants for the burst read query table: offsets, codes and reset values
//
// Overview of operation
// - page size exponent 03 at 0x127, 8-byte page
// - page exponent zero means no page buffer
// - 0x128 reports four synchronous entries; zero means none
// - entry bits 0-2 burst code, 3-7 reserved
// - entry code 07h means continuous linear bursting
// - entries 0x129-0x12C read 01, 02, 03, 07
// - 0x12D reports partition regions; zero means single
// - nonzero count gives number of partition regions
// - reserved and undefined bits read as zero
`ifndef BURST_READ_QUERY_TABLE_DEFINES_SVH
`define BURST_READ_QUERY_TABLE_DEFINES_SVH

// query location indices, byte address is four times the index
`define PAGE_SIZE_IDX 10'h127
`define ENTRY_COUNT_IDX 10'h128
`define ENTRY_ONE_IDX 10'h129
`define ENTRY_TWO_IDX 10'h12a
`define ENTRY_THREE_IDX 10'h12b
`define ENTRY_FOUR_IDX 10'h12c
`define PART_COUNT_IDX 10'h12d
`define QUERY_CTRL_IDX 10'h130

// constant contents of the table
`define PAGE_SIZE_CODE 8'h03
`define ENTRY_COUNT_CODE 8'h04
`define ENTRY_ONE_CODE 8'h01
`define ENTRY_TWO_CODE 8'h02
`define ENTRY_THREE_CODE 8'h03
`define ENTRY_FOUR_CODE 8'h07
`define PART_COUNT_CODE 8'h01
`define BURST_CONTINUOUS 3'h7

// field layout
`define BURST_CODE_MASK 8'h07
`define QUERY_EN_BIT 0
`define QUERY_EN_RESET 1'b1
`define PRDATA_RESET 32'h0000_0000
`define PSLVERR_RESET 1'b0

`endif

// file: verilog/burst_read_query_table_pkg.sv
// types shared by the burst read query table
`default_nettype none
package burst_read_query_table_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // whole state of the table
  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
    logic query_en;
  } state_s;

endpackage
`default_nettype wire
